// File: core/mev_math_eval.v
`timescale 1ns/10ps
`include "mev_consts.vh"
module mev_math_eval #(
  parameter       AW             = 32,
  parameter       IW             = `MEV_IW,
  parameter [7:0] EVAL_BLOCK_NUM = 8'h01
) (
  core_clk,
  rst_n,
  scan_tick,
  en,
  hold_on_disable,
  operand_one_const,
  operand_one_use_block,
  operand_one_actual,
  operand_two_const,
  operand_two_use_block,
  operand_two_actual,
  operand_three_const,
  operand_three_use_block,
  operand_three_actual,
  operand_four_const,
  operand_four_use_block,
  operand_four_actual,
  operator_first,
  operator_second,
  operator_third,
  prio_first,
  prio_second,
  prio_third,
  decimals,
  eval_before_detect,
  det_en,
  det_clear,
  source_block_ref,
  err_select,
  auto_clear,
  result_out,
  div_zero_flag,
  overflow_flag,
  busy,
  scan_done,
  error_out,
  display_decimals
);
  input  wire          core_clk;
  input  wire          rst_n;
  input  wire          scan_tick;
  input  wire          en;
  input  wire          hold_on_disable;
  input  wire [15:0]   operand_one_const;
  input  wire          operand_one_use_block;
  input  wire [AW-1:0] operand_one_actual;
  input  wire [15:0]   operand_two_const;
  input  wire          operand_two_use_block;
  input  wire [AW-1:0] operand_two_actual;
  input  wire [15:0]   operand_three_const;
  input  wire          operand_three_use_block;
  input  wire [AW-1:0] operand_three_actual;
  input  wire [15:0]   operand_four_const;
  input  wire          operand_four_use_block;
  input  wire [AW-1:0] operand_four_actual;
  input  wire [1:0]    operator_first;
  input  wire [1:0]    operator_second;
  input  wire [1:0]    operator_third;
  input  wire [1:0]    prio_first;
  input  wire [1:0]    prio_second;
  input  wire [1:0]    prio_third;
  input  wire [1:0]    decimals;
  input  wire          eval_before_detect;
  input  wire          det_en;
  input  wire          det_clear;
  input  wire [7:0]    source_block_ref;
  input  wire [1:0]    err_select;
  input  wire          auto_clear;
  output wire [15:0]   result_out;
  output wire          div_zero_flag;
  output wire          overflow_flag;
  output wire          busy;
  output wire          scan_done;
  output wire          error_out;
  output wire [1:0]    display_decimals;

  // ===========================================================
  // States
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_LOAD = 4'h2;
  localparam [3:0] ST_CALC = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // ===========================================================
  // Functions
  function [15:0] clamp_src;
    input [AW-1:0] v;
    begin
      if ((&v[AW-1:15]) || !(|v[AW-1:15])) begin
        clamp_src = v[15:0];
      end else if (v[AW-1]) begin
        clamp_src = `MEV_RES_MIN;
      end else begin
        clamp_src = `MEV_RES_MAX;
      end
    end
  endfunction

  function [IW-1:0] widen;
    input [15:0] v;
    begin
      widen = {{(IW-16){v[15]}}, v};
    end
  endfunction

  // Leftmost operator of the highest bracket level wins
  function [1:0] pick_op;
    input [5:0] prio;
    input [1:0] cnt;
    integer i;
    reg [1:0] best;
    begin
      best = 2'h0;
      for (i = 1; i < 3; i = i + 1) begin
        if (i < cnt && prio[2*i +: 2] > prio[2*best +: 2]) begin
          best = i[1:0];
        end
      end
      pick_op = best;
    end
  endfunction

  // Drops entry k from a packed list of three 2-bit entries
  function [5:0] drop_entry;
    input [5:0] lst;
    input [1:0] k;
    integer j;
    reg [5:0] r;
    begin
      r = 6'h00;
      for (j = 0; j < 2; j = j + 1) begin
        if (j < k) begin
          r[2*j +: 2] = lst[2*j +: 2];
        end else begin
          r[2*j +: 2] = lst[2*j+2 +: 2];
        end
      end
      drop_entry = r;
    end
  endfunction

  // ===========================================================
  // Registers
  reg [3:0]    state_q;
  reg          en_d_q;
  reg          armed_q;
  reg [IW-1:0] vals_q [0:3];
  reg [5:0]    ops_q;
  reg [5:0]    prio_q;
  reg [1:0]    cnt_q;
  reg [15:0]   result_q;
  reg          dz_q;
  reg          ov_q;
  reg [1:0]    dec_q;

  // ===========================================================
  // Enable edge
  wire en_rise;

  assign en_rise = en & ~en_d_q;

  // ===========================================================
  // Operand selection
  wire [15:0] opnd [0:3];
  wire [15:0] const_in [0:3];
  wire [AW-1:0] act_in [0:3];
  wire [3:0] use_blk;

  assign const_in[0] = operand_one_const;
  assign const_in[1] = operand_two_const;
  assign const_in[2] = operand_three_const;
  assign const_in[3] = operand_four_const;
  assign act_in[0] = operand_one_actual;
  assign act_in[1] = operand_two_actual;
  assign act_in[2] = operand_three_actual;
  assign act_in[3] = operand_four_actual;
  assign use_blk = {operand_four_use_block, operand_three_use_block,
                    operand_two_use_block, operand_one_use_block};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_opnd
      assign opnd[g] = use_blk[g] ? clamp_src(act_in[g]) : const_in[g];
    end
  endgenerate

  // ===========================================================
  // Step datapath
  wire [1:0]    k_sel;
  wire [IW-1:0] step_y;
  wire          step_dz;
  wire          step_rerr;
  wire          step_neg;
  wire [1:0]    step_op;
  wire          final_fits;
  wire [15:0]   final_sat;

  assign k_sel = pick_op(prio_q, cnt_q);
  assign step_op = ops_q[2*k_sel +: 2];

  mev_arith #(
    .W (IW)
  ) u_arith (
    .a         (vals_q[k_sel]),
    .b         (vals_q[k_sel + 2'h1]),
    .op        (step_op),
    .y         (step_y),
    .div_zero  (step_dz),
    .range_err (step_rerr),
    .neg       (step_neg)
  );

  // Final value outside 16 bits saturates by its sign
  assign final_fits = (&step_y[IW-1:15]) || !(|step_y[IW-1:15]);
  assign final_sat = step_y[IW-1] ? `MEV_RES_MIN : `MEV_RES_MAX;

  // ===========================================================
  // Sequencer
  integer i;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      // High at reset so an enable already high does not arm
      en_d_q <= 1'b1;
      armed_q <= 1'b0;
      ops_q <= 6'h00;
      prio_q <= 6'h00;
      cnt_q <= 2'h0;
      result_q <= `MEV_RES_ZERO;
      dz_q <= 1'b0;
      ov_q <= 1'b0;
      dec_q <= 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
        vals_q[i] <= {IW{1'b0}};
      end
    end else begin
      en_d_q <= en;
      dec_q <= decimals;
      if (!en) begin
        armed_q <= 1'b0;
      end else if (en_rise) begin
        armed_q <= 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          if (scan_tick) begin
            state_q <= armed_q ? ST_LOAD : ST_DONE;
          end
        end
        ST_LOAD: begin
          // Operands and operators are frozen for the whole scan
          for (i = 0; i < 4; i = i + 1) begin
            vals_q[i] <= widen(opnd[i]);
          end
          ops_q <= {operator_third, operator_second, operator_first};
          prio_q <= {prio_third, prio_second, prio_first};
          cnt_q <= `MEV_NUM_OPS;
          state_q <= ST_CALC;
        end
        ST_CALC: begin
          // An error ends the scan at once; later steps are skipped
          if (step_dz) begin
            dz_q <= 1'b1;
            ov_q <= 1'b0;
            result_q <= `MEV_RES_MAX;
            state_q <= ST_DONE;
          end else if (step_rerr) begin
            dz_q <= 1'b0;
            ov_q <= 1'b1;
            result_q <= step_neg ? `MEV_RES_MIN : `MEV_RES_MAX;
            state_q <= ST_DONE;
          end else begin
            vals_q[k_sel] <= step_y;
            for (i = 1; i < 3; i = i + 1) begin
              if (i > k_sel) begin
                vals_q[i] <= vals_q[i+1];
              end
            end
            ops_q <= drop_entry(ops_q, k_sel);
            prio_q <= drop_entry(prio_q, k_sel);
            cnt_q <= cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
              dz_q <= 1'b0;
              ov_q <= ~final_fits;
              result_q <= final_fits ? step_y[15:0] : final_sat;
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // Clearing on disable wins over a late write
      if (!en && !hold_on_disable) begin
        result_q <= `MEV_RES_ZERO;
      end
    end
  end

  // ===========================================================
  // Error detector
  wire det_exec;
  wire ref_valid;

  // Evaluator first: detector runs after it finishes; otherwise at scan start
  assign det_exec = eval_before_detect ? state_q[3] : scan_tick;
  assign ref_valid = (source_block_ref != `MEV_NULL_REF) &&
                     (source_block_ref == EVAL_BLOCK_NUM);

  mev_err_detect u_err_detect (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .det_en        (det_en),
    .det_clear     (det_clear),
    .det_exec      (det_exec),
    .ref_valid     (ref_valid),
    .err_select    (err_select),
    .auto_clear    (auto_clear),
    .div_zero_flag (dz_q),
    .overflow_flag (ov_q),
    .error_out     (error_out)
  );

  // ===========================================================
  // Outputs
  assign result_out = result_q;
  assign div_zero_flag = dz_q;
  assign overflow_flag = ov_q;
  assign busy = ~state_q[0];
  assign scan_done = state_q[3];
  assign display_decimals = dec_q;

endmodule // mev_math_eval

// File: core/mev_consts.vh
// Summary of operation
// - Evaluator arms on enable rising edge
// - Divide by zero or overflow saturates result
// - Out-of-range source values clamp to limits
// - Four operands, three operators, fixed order
// - Operators: add, subtract, multiply, divide
// - Round brackets first, square next, unmarked last
// - Result rounded to nearest integer
// - Disabled: result zero or held per setting
// - Zero-division and overflow flags updated per execution
// - Detector arms on enable rising edge
// - Detector output follows selected error kind
// - Auto-clear clears output before each execution
// - Without auto-clear output latches until clear
// - Clear input drives detector output low; an execution in the same cycle wins
// - Execution order decides same or next scan
// - No referenced evaluator keeps output zero
// - Operand is constant or another block's value
// - Decimal places affect display only
`ifndef MEV_CONSTS_VH
`define MEV_CONSTS_VH

`define MEV_RES_MAX     16'h7FFF
`define MEV_RES_MIN     16'h8000
`define MEV_RES_ZERO    16'h0000
`define MEV_IW          40

`define MEV_OP_ADD      2'h0
`define MEV_OP_SUB      2'h1
`define MEV_OP_MUL      2'h2
`define MEV_OP_DIV      2'h3

`define MEV_PRIO_NONE   2'h0
`define MEV_PRIO_SQUARE 2'h1
`define MEV_PRIO_ROUND  2'h2

`define MEV_ERR_DIV0    2'h0
`define MEV_ERR_OVF     2'h1
`define MEV_ERR_ANY     2'h2

`define MEV_NUM_OPS     2'h3
`define MEV_NULL_REF    8'h00

`endif

// File: core/mev_arith.v
`timescale 1ns/10ps
`include "mev_consts.vh"
module mev_arith #(
  parameter W = `MEV_IW
) (
  a,
  b,
  op,
  y,
  div_zero,
  range_err,
  neg
);
  input  wire signed [W-1:0] a;
  input  wire signed [W-1:0] b;
  input  wire        [1:0]   op;
  output reg  signed [W-1:0] y;
  output reg                 div_zero;
  output reg                 range_err;
  output reg                 neg;

  reg signed [2*W-1:0] wa;
  reg signed [2*W-1:0] wb;
  reg signed [2*W-1:0] wide;
  reg signed [2*W-1:0] wr;
  reg        [2*W-1:0] ar;
  reg        [2*W-1:0] ab;

  // ===========================================================
  // One binary step, computed at double width
  always @* begin
    wa = {{W{a[W-1]}}, a};
    wb = {{W{b[W-1]}}, b};
    wide = {(2*W){1'b0}};
    wr = {(2*W){1'b0}};
    ar = {(2*W){1'b0}};
    ab = {(2*W){1'b0}};
    div_zero = 1'b0;
    case (op)
      `MEV_OP_ADD: wide = wa + wb;
      `MEV_OP_SUB: wide = wa - wb;
      `MEV_OP_MUL: wide = wa * wb;
      `MEV_OP_DIV: begin
        if (b == {W{1'b0}}) begin
          div_zero = 1'b1;
        end else begin
          wide = wa / wb;
          wr = wa % wb;
          ar = wr[2*W-1] ? -wr : wr;
          ab = wb[2*W-1] ? -wb : wb;
          // Half or more of the divisor rounds away from zero
          if ({ar[2*W-2:0], 1'b0} >= ab) begin
            wide = (wa[2*W-1] ^ wb[2*W-1]) ? wide - 1 : wide + 1;
          end
        end
      end
      default: wide = wa;
    endcase
    neg = wide[2*W-1];
    range_err = ~((&wide[2*W-1:W-1]) | ~(|wide[2*W-1:W-1]));
    y = wide[W-1:0];
  end
endmodule // mev_arith

// File: core/mev_err_detect.v
`timescale 1ns/10ps
`include "mev_consts.vh"
module mev_err_detect (
  core_clk,
  rst_n,
  det_en,
  det_clear,
  det_exec,
  ref_valid,
  err_select,
  auto_clear,
  div_zero_flag,
  overflow_flag,
  error_out
);
  input  wire       core_clk;
  input  wire       rst_n;
  input  wire       det_en;
  input  wire       det_clear;
  input  wire       det_exec;
  input  wire       ref_valid;
  input  wire [1:0] err_select;
  input  wire       auto_clear;
  input  wire       div_zero_flag;
  input  wire       overflow_flag;
  output wire       error_out;

  reg en_d_q;
  reg armed_q;
  reg out_q;
  reg out_d;
  reg sel_err;

  // ===========================================================
  // Error selection and output latch
  always @* begin
    case (err_select)
      `MEV_ERR_DIV0: sel_err = div_zero_flag;
      `MEV_ERR_OVF:  sel_err = overflow_flag;
      `MEV_ERR_ANY:  sel_err = div_zero_flag | overflow_flag;
      default:       sel_err = 1'b0;
    endcase
    out_d = out_q;
    if (det_clear) begin
      out_d = 1'b0;
    end
    if (det_exec && armed_q) begin
      if (auto_clear) begin
        out_d = sel_err;
      end else begin
        out_d = out_d | sel_err;
      end
    end
    if (!ref_valid) begin
      out_d = 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      // High at reset so an enable already high does not arm
      en_d_q <= 1'b1;
      armed_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      en_d_q <= det_en;
      if (!det_en) begin
        armed_q <= 1'b0;
      end else if (!en_d_q) begin
        armed_q <= 1'b1;
      end
      out_q <= out_d;
    end
  end

  assign error_out = out_q;
endmodule // mev_err_detect

// File: tb/mev_math_eval_assertions.sv
`timescale 1ns/10ps
`include "mev_consts.vh"
// ====
// Port checker
module mev_math_eval_assertions #(
  parameter [7:0] EVAL_BLOCK_NUM = 8'h01
) (
  input wire        core_clk,
  input wire        rst_n,
  input wire        scan_tick,
  input wire        en,
  input wire        hold_on_disable,
  input wire        det_clear,
  input wire [7:0]  source_block_ref,
  input wire        auto_clear,
  input wire [15:0] result_out,
  input wire        div_zero_flag,
  input wire        overflow_flag,
  input wire        busy,
  input wire        scan_done,
  input wire        error_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    scan_tick && !busy;
  endsequence
  sequence s_err_set;
    $rose(error_out);
  endsequence
  done_bound_a: assert property (s_taken |-> ##[1:6] scan_done)
    else $error("scan did not finish");
  done_pulse_a: assert property (scan_done |=> !scan_done)
    else $error("scan_done too long");
  busy_cause_a: assert property ($rose(busy) |-> $past(scan_tick))
    else $error("busy without tick");
  dz_sat_a: assert property ($rose(div_zero_flag) && $past(en) |->
    result_out == `MEV_RES_MAX && !overflow_flag) else $error("zero div result wrong");
  ovf_sat_a: assert property ($rose(overflow_flag) && $past(en) |->
    result_out == `MEV_RES_MAX || result_out == `MEV_RES_MIN) else $error("overflow not saturated");
  dis_clear_a: assert property (!en && !hold_on_disable |=> result_out == `MEV_RES_ZERO)
    else $error("result not cleared");
  dis_hold_a: assert property (!en && hold_on_disable && !busy |=> $stable(result_out))
    else $error("result not held");
  err_cause_a: assert property (s_err_set |-> $past(source_block_ref) == EVAL_BLOCK_NUM &&
    ($past(div_zero_flag) || $past(overflow_flag))) else $error("error out without cause");
  clr_low_a: assert property (det_clear && !scan_tick && !scan_done |=> !error_out)
    else $error("clear ignored");
  sticky_out_a: assert property (!auto_clear && error_out && !det_clear |=> error_out)
    else $error("sticky output dropped");
endmodule // mev_math_eval_assertions

bind mev_math_eval mev_math_eval_assertions #(.EVAL_BLOCK_NUM(EVAL_BLOCK_NUM)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .scan_tick(scan_tick), .en(en),
  .hold_on_disable(hold_on_disable), .det_clear(det_clear), .source_block_ref(source_block_ref),
  .auto_clear(auto_clear), .result_out(result_out), .div_zero_flag(div_zero_flag),
  .overflow_flag(overflow_flag), .busy(busy), .scan_done(scan_done), .error_out(error_out));

// File: tb/mev_src_blocks.sv
`timescale 1ns/10ps
// ====
// Source function blocks feeding actual values
module mev_src_blocks (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire             scan_tick,
  input  wire [3:0][31:0] want,
  output reg  [3:0][31:0] act
);
  // Actual values refresh at scan start and hold through the scan
  always @(posedge core_clk) begin
    if (!rst_n) begin
      act <= '0;
    end else if (scan_tick) begin
      act <= want;
    end
  end
endmodule // mev_src_blocks

// File: tb/mev_math_eval_test.sv
`timescale 1ns/10ps
// ====
// Bench
module mev_math_eval_test;
  logic             core_clk, rst_n, scan_tick, en, hold_on_disable, det_en, det_clear;
  logic             eval_before_detect, auto_clear, busy, scan_done, error_out;
  logic             div_zero_flag, overflow_flag;
  logic [3:0]       use_blk;
  logic [3:0][31:0] want, act;
  logic [15:0]      cst [4];
  logic [1:0]       opr [3];
  logic [1:0]       pri [3];
  logic [1:0]       decimals, err_select, display_decimals;
  logic [7:0]       source_block_ref;
  logic [15:0]      result_out, m_res;
  bit               m_dz, m_ov, p_dz, p_ov, m_err, d_arm;
  bit   [31:0]      seed;
  int               n_fail, n_checks, cyc;

  mev_src_blocks u_src (.core_clk(core_clk), .rst_n(rst_n), .scan_tick(scan_tick), .want(want), .act(act));
  mev_math_eval u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .scan_tick(scan_tick), .en(en), .hold_on_disable(hold_on_disable),
    .operand_one_const(cst[0]), .operand_one_use_block(use_blk[0]), .operand_one_actual(act[0]),
    .operand_two_const(cst[1]), .operand_two_use_block(use_blk[1]), .operand_two_actual(act[1]),
    .operand_three_const(cst[2]), .operand_three_use_block(use_blk[2]), .operand_three_actual(act[2]),
    .operand_four_const(cst[3]), .operand_four_use_block(use_blk[3]), .operand_four_actual(act[3]),
    .operator_first(opr[0]), .operator_second(opr[1]), .operator_third(opr[2]),
    .prio_first(pri[0]), .prio_second(pri[1]), .prio_third(pri[2]), .decimals(decimals),
    .eval_before_detect(eval_before_detect), .det_en(det_en), .det_clear(det_clear),
    .source_block_ref(source_block_ref), .err_select(err_select), .auto_clear(auto_clear),
    .result_out(result_out), .div_zero_flag(div_zero_flag), .overflow_flag(overflow_flag),
    .busy(busy), .scan_done(scan_done), .error_out(error_out), .display_decimals(display_decimals));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic longint clampv(longint x);
    return x > 32767 ? 32767 : (x < -32768 ? -32768 : x);
  endfunction

  // Reference evaluation: highest mark first, leftmost on ties
  function automatic void model();
    longint v[$];
    longint a, b, r;
    int     o[$];
    int     p[$];
    int     k;
    m_dz = 1'b0;
    for (int i = 0; i < 4; i++)
      v.push_back(use_blk[i] ? clampv($signed(want[i])) : longint'($signed(cst[i])));
    for (int i = 0; i < 3; i++) begin
      o.push_back(opr[i]);
      p.push_back(pri[i]);
    end
    while (o.size() > 0) begin
      k = 0;
      for (int i = 1; i < o.size(); i++)
        if (p[i] > p[k])
          k = i;
      a = v[k];
      b = v[k+1];
      if (o[k] == 3 && b == 0) begin
        m_dz = 1'b1;
        m_ov = 1'b0;
        m_res = 16'h7FFF;
        return;
      end
      case (o[k])
        0: r = a + b;
        1: r = a - b;
        2: r = a * b;
        default: begin
          r = (2 * (a < 0 ? -a : a) + (b < 0 ? -b : b)) / (2 * (b < 0 ? -b : b));
          if ((a < 0) != (b < 0))
            r = -r;
        end
      endcase
      v[k] = r;
      v.delete(k + 1);
      o.delete(k);
      p.delete(k);
    end
    m_ov = v[0] > 32767 || v[0] < -32768;
    m_res = 16'(clampv(v[0]));
  endfunction

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic set_eq(input logic [63:0] v, input logic [5:0] o, p, input logic [3:0] ub);
    @(posedge core_clk);
    use_blk <= ub;
    for (int i = 0; i < 4; i++)
      cst[i] <= v[63-16*i -: 16];
    for (int i = 0; i < 3; i++) begin
      opr[i] <= o[5-2*i -: 2];
      pri[i] <= p[5-2*i -: 2];
    end
  endtask

  task automatic run_scan(input bit ex);
    bit [1:0] f;
    bit       s;
    decimals <= 2'(xs());
    repeat (3) @(posedge core_clk);
    scan_tick <= 1'b1;
    @(posedge core_clk);
    scan_tick <= 1'b0;
    for (int i = 0; i < 12 && scan_done !== 1'b1; i++)
      @(posedge core_clk);
    @(posedge core_clk);
    if (ex)
      model();
    f = eval_before_detect ? {m_dz, m_ov} : {p_dz, p_ov};
    s = err_select == 2'h0 ? f[1] : err_select == 2'h1 ? f[0] : err_select == 2'h2 ? |f : 1'b0;
    if (source_block_ref != 8'h01)
      s = 1'b0;
    if (d_arm)
      m_err = auto_clear ? s : m_err | s;
    chk("result", m_res, result_out);
    chk("zero div flag", 16'(m_dz), 16'(div_zero_flag));
    chk("overflow flag", 16'(m_ov), 16'(overflow_flag));
    chk("error out", 16'(m_err), 16'(error_out));
    chk("decimals", 16'(decimals), 16'(display_decimals));
    p_dz = m_dz;
    p_ov = m_ov;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    seed = 32'h30B9B40E;
    {rst_n, scan_tick, hold_on_disable, det_clear, use_blk, want, decimals} = '0;
    {en, det_en, eval_before_detect, auto_clear} = 4'hF;
    source_block_ref = 8'h01;
    err_select = 2'h2;
    m_res = 16'h0000;
    foreach (cst[i])
      cst[i] = 16'h0000;
    foreach (opr[i]) begin
      opr[i] = 2'h0;
      pri[i] = 2'h0;
    end
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    set_eq(64'h0001_0000_0000_0000, 6'h30, 6'h00, 4'h0);
    run_scan(1'b0);
    en <= 1'b0;
    det_en <= 1'b0;
    @(posedge core_clk);
    en <= 1'b1;
    det_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    d_arm = 1'b1;
    run_scan(1'b1);
    $display("test arming done");
    set_eq(64'h000C_0006_0003_0001, 6'h0D, 6'h18, 4'h0);
    run_scan(1'b1);
    set_eq(64'h0002_0003_0001_0004, 6'h08, 6'h06, 4'h0);
    run_scan(1'b1);
    set_eq(64'h0064_0019_0002_0001, 6'h1C, 6'h21, 4'h0);
    run_scan(1'b1);
    for (int n = 0; n < 60; n++) begin
      for (int i = 0; i < 4; i++) begin
        cst[i] <= 16'(int'(xs() % 4001) - 2000);
        want[i] <= 32'(int'(xs() % 4001) - 2000);
        use_blk[i] <= 1'(xs());
      end
      for (int i = 0; i < 3; i++) begin
        opr[i] <= 2'(xs());
        pri[i] <= 2'(xs());
      end
      run_scan(1'b1);
    end
    $display("test equations done");
    set_eq(64'h0, 6'h10, 6'h00, 4'hF);
    want <= {32'h0, 32'h0, 32'h1, 32'h00009C40};
    run_scan(1'b1);
    set_eq(64'h0, 6'h00, 6'h00, 4'hF);
    want <= {32'h0, 32'h0, 32'h5, 32'hFFFEA070};
    run_scan(1'b1);
    set_eq(64'h7530_2710_0000_0000, 6'h00, 6'h00, 4'h0);
    run_scan(1'b1);
    set_eq(64'h8AD0_2710_0000_0000, 6'h10, 6'h00, 4'h0);
    run_scan(1'b1);
    hold_on_disable <= 1'b1;
    en <= 1'b0;
    run_scan(1'b0);
    hold_on_disable <= 1'b0;
    m_res = 16'h0000;
    run_scan(1'b0);
    en <= 1'b1;
    repeat (2) @(posedge core_clk);
    $display("test limits done");
    for (int r = 0; r < 3; r++)
      for (int s = 0; s < 4; s++)
        for (int k = 0; k < 4; k++) begin
          @(posedge core_clk);
          source_block_ref <= 8'(r);
          err_select <= 2'(s);
          auto_clear <= k[0];
          eval_before_detect <= k[1];
          det_clear <= 1'b1;
          @(posedge core_clk);
          det_clear <= 1'b0;
          m_err = 1'b0;
          @(posedge core_clk);
          chk("cleared", 16'h0000, 16'(error_out));
          set_eq(64'h0001_0000_0000_0000, 6'h30, 6'h00, 4'h0);
          run_scan(1'b1);
          set_eq(64'h7530_2710_0000_0000, 6'h00, 6'h00, 4'h0);
          run_scan(1'b1);
          set_eq(64'h0001_0001_0000_0000, 6'h00, 6'h00, 4'h0);
          run_scan(1'b1);
        end
    $display("test detector done");
    close_out();
  end
endmodule // mev_math_eval_test
